// *** scc_ctrl.sv ***
// Symmetric cipher control, status, error and FIFO logic behind an Avalon-MM slave
module scc_ctrl #(
	parameter int DEPTH = scc_pkg::FIFO_DEPTH
) (
	input  wire logic        I_CLK,
	input  wire logic        I_RST,
	input  wire logic        I_CE,
	input  wire logic [23:0] I_AVS_ADDRESS,
	input  wire logic        I_AVS_READ,
	input  wire logic        I_AVS_WRITE,
	input  wire logic [31:0] I_AVS_WRITEDATA,
	input  wire logic [3:0]  I_AVS_BYTEENABLE,
	output logic      [31:0] O_AVS_READDATA,
	output logic             O_AVS_WAITREQUEST,
	output logic             O_IRQ
);
	localparam int CW = $clog2(DEPTH + 1);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	// ************************************
	// Helpers
	// ************************************
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[8*i +: 8] = d[8*i +: 8];
			end
		end
		return r;
	endfunction

	// Any enabled key byte without odd parity
	function automatic logic par_err(input logic [31:0] d, input logic [3:0] be);
		logic r;
		r = 1'b0;
		for (int i = 0; i < 4; i++) begin
			r = r | (be[i] & ~(^d[8*i +: 8]));
		end
		return r;
	endfunction

	function automatic logic [PW-1:0] inc(input logic [PW-1:0] p);
		return (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	function automatic scc_pkg::scc_mode_s to_mode(input logic [31:0] d);
		return scc_pkg::scc_mode_s'({d[11:7], d[4:0]});
	endfunction

	// Reserved bits, reserved codes and impossible combinations
	function automatic logic mode_bad(input logic [31:0] d);
		scc_pkg::scc_mode_s m;
		m = to_mode(d);
		return (|d[31:12]) | (|d[6:5]) | (m.algorithm_select == scc_pkg::ALG_RSV)
			| (m.cm == scc_pkg::CM_RSV)
			| (m.parity_check_disable & (m.algorithm_select == scc_pkg::ALG_AES))
			| ((m.algorithm_select != scc_pkg::ALG_AES) & m.ctrm[3]);
	endfunction

	// ************************************
	// State
	// ************************************
	logic                   wait_q;
	logic [31:0]            rdata_q;
	logic                   irq_o;
	logic                   ie_q;
	logic [10:0]            mask_q;
	scc_pkg::scc_mode_s     md_q;
	scc_pkg::scc_state_e    st;
	logic                   go_q;
	logic                   done_q;
	logic                   irq_q;
	logic                   rdone_q;
	logic [10:0]            err_q;
	logic [5:0]             ksz_q;
	logic                   key_ok;
	logic                   par_q;
	logic [31:0]            dsz_q;
	logic [1:0]             widx;
	logic [31:0]            in_mem [DEPTH];
	logic [31:0]            out_mem [DEPTH];
	logic [PW-1:0]          in_wp, in_rp, out_wp, out_rp;
	logic [CW-1:0]          in_cnt, out_cnt;

	// ************************************
	// Bus decode
	// ************************************
	// One access edge per request; waitrequest drops in the next cycle
	wire acc = (I_AVS_READ | I_AVS_WRITE) & wait_q & I_CE;
	wire wr = acc & I_AVS_WRITE;
	wire rd = acc & I_AVS_READ;
	wire [23:0] a = I_AVS_ADDRESS;
	wire [31:0] d = I_AVS_WRITEDATA;
	wire [3:0] be = I_AVS_BYTEENABLE;
	wire hit_mode = a == scc_pkg::A_MODE;
	wire hit_ctrl = a == scc_pkg::A_CTRL;
	wire hit_cmd = a == scc_pkg::A_CMD;
	wire hit_stat = a == scc_pkg::A_STAT;
	wire hit_err = a == scc_pkg::A_ERR;
	wire hit_mask = a == scc_pkg::A_MASK;
	wire hit_ksz = a == scc_pkg::A_KSZ;
	wire hit_dsz = a == scc_pkg::A_DSZ;
	wire hit_in = a == scc_pkg::A_IN;
	wire hit_out = a == scc_pkg::A_OUT;
	wire al = a[1:0] == 2'h0;
	wire hit_key = al & (a >= scc_pkg::A_KEY0) & (a <= scc_pkg::A_KEY5);
	wire hit_ctx = al & (a >= scc_pkg::A_CTX0) & (a <= scc_pkg::A_CTX11);

	// Self-clearing commands act on the access edge only
	wire cmd_w = wr & hit_cmd & be[0];
	wire go_w = cmd_w & d[scc_pkg::CMD_GO];
	wire ci = cmd_w & d[scc_pkg::CMD_CI];
	wire ri = cmd_w & d[scc_pkg::CMD_RI];
	wire soft_reset_cmd = cmd_w & d[scc_pkg::CMD_SWR];

	// ************************************
	// Engine sequencing
	// ************************************
	wire busy = st == scc_pkg::ST_RUN;
	wire in_empty = in_cnt == '0;
	wire in_full = in_cnt == CW'(DEPTH);
	wire out_empty = out_cnt == '0;
	wire out_full = out_cnt == CW'(DEPTH);
	wire start = (st == scc_pkg::ST_IDLE) & key_ok & (dsz_q != '0);
	// Word moved through the stand-in datapath; the rounds live elsewhere
	wire mv = busy & ~in_empty & ~out_full & (dsz_q != '0);
	wire fin = (st != scc_pkg::ST_HALT) & go_q & (dsz_q == '0);
	wire in_push = wr & hit_in & ~in_full;
	wire out_pop = rd & hit_out & ~out_empty;

	// Key size legal per algorithm
	wire ks_bad = (md_q.algorithm_select == scc_pkg::ALG_AES) ? (d[5:0] != scc_pkg::KS_16)
		: (md_q.algorithm_select == 2'h1) ? (d[5:0] != scc_pkg::KS_8)
		: ((d[5:0] != scc_pkg::KS_16) & (d[5:0] != scc_pkg::KS_24));
	wire [31:0] ds_add = merge('0, d, be);
	// DES and AES-CTR need 8-byte multiples, other AES 16
	wire ds_bad = ((md_q.algorithm_select != scc_pkg::ALG_AES) | (md_q.cm == scc_pkg::CM_CTR))
		? (ds_add[2:0] != 3'h0) : (ds_add[3:0] != 4'h0);
	wire ks_w = wr & hit_ksz & ~busy;

	// ************************************
	// Error events
	// ************************************
	logic [10:0] evt;
	assign evt[scc_pkg::E_KRE] = rd & busy & hit_key;
	assign evt[scc_pkg::E_KPE] = ks_w & (md_q.algorithm_select != scc_pkg::ALG_AES) & ~md_q.parity_check_disable & par_q;
	assign evt[scc_pkg::E_ERE] = rd & busy & hit_ctx;
	assign evt[scc_pkg::E_RMD] = wr & busy & (hit_mode | hit_ksz | hit_key | hit_ctx);
	assign evt[scc_pkg::E_KSE] = ks_w & ks_bad;
	assign evt[scc_pkg::E_DSE] = wr & hit_dsz & ds_bad;
	assign evt[scc_pkg::E_IME] = wr & hit_mode & ~busy & mode_bad(d);
	assign evt[scc_pkg::E_OUT_FIFO_NONEMPTY_AT_START] = start & ~out_empty;
	assign evt[scc_pkg::E_IN_FIFO_NONEMPTY_AT_DONE] = fin & ~in_empty;
	assign evt[scc_pkg::E_OFU] = rd & hit_out & out_empty;
	assign evt[scc_pkg::E_IFO] = wr & hit_in & in_full;

	// Only the first unmasked error is kept; masked ones pile up before it
	wire [10:0] err_base = ci ? scc_pkg::ERR_RST : err_q;
	wire rec = ~|(err_base & ~mask_q);
	wire unm = rec & |(evt & ~mask_q);
	wire [10:0] next_err = err_base | (rec ? evt : scc_pkg::ERR_RST);

	// ************************************
	// Next values
	// ************************************
	// New events win over a clear in the same cycle
	wire next_irq = fin | unm | (irq_q & ~ci);
	wire next_go = go_w | (go_q & ~fin);
	wire next_done = fin | (done_q & ~start);
	// Byte-lane merges as named words, sliced where they are used
	wire [31:0] ctrl_new = merge({31'h0, ie_q}, d, be);
	wire [31:0] mask_new = merge({21'h0, mask_q}, d, be);
	wire [31:0] ksz_new = merge({26'h0, ksz_q}, d, be);
	wire next_ie = (wr & hit_ctrl) ? ctrl_new[0] : ie_q;
	wire [10:0] next_mask = (wr & hit_mask) ? mask_new[10:0] : mask_q;
	wire next_key_ok = ks_w ? ~ks_bad : key_ok;
	wire next_par = ks_w ? 1'b0 : (par_q | (wr & hit_key & ~busy & par_err(d, be)));
	wire [31:0] dec = (dsz_q < scc_pkg::WORD_BYTES) ? dsz_q : scc_pkg::WORD_BYTES;
	// Writes add to the remaining count, even mid-message
	wire [31:0] next_dsz = dsz_q + ((wr & hit_dsz) ? ds_add : '0) - (mv ? dec : '0);
	wire [31:0] mode_new = merge({20'h0, md_q.ctrm, md_q.parity_check_disable, 2'h0, md_q.cm, md_q.dir, md_q.algorithm_select}, d, be);
	wire mode_w = wr & hit_mode & ~busy;
	wire [CW-1:0] next_in_cnt = in_cnt + CW'(in_push) - CW'(mv);
	wire [CW-1:0] next_out_cnt = out_cnt + CW'(mv) - CW'(out_pop);

	logic [2:0] next_st;
	always_comb begin
		case (st)
			scc_pkg::ST_IDLE: next_st = unm ? scc_pkg::ST_HALT : start ? scc_pkg::ST_RUN : scc_pkg::ST_IDLE;
			scc_pkg::ST_RUN: next_st = unm ? scc_pkg::ST_HALT : fin ? scc_pkg::ST_IDLE : scc_pkg::ST_RUN;
			scc_pkg::ST_HALT: next_st = scc_pkg::ST_HALT;
			default: next_st = scc_pkg::ST_HALT;
		endcase
	end

	// ************************************
	// Read data and status
	// ************************************
	wire [4:0] wide_st = (md_q.algorithm_select == scc_pkg::ALG_AES) ? {widx, st} : 5'h00;
	wire [2:0] narrow_st = (md_q.algorithm_select != scc_pkg::ALG_AES) ? {widx[0], st[2:1]} : 3'h0;
	wire [31:0] stat_w = {8'(out_cnt), 8'(in_cnt), wide_st, narrow_st, 3'h0,
		busy, rdone_q, |err_q, done_q, irq_q & ie_q};
	// Input port, key and context read as zero here
	wire [31:0] rd_mux = hit_mode ? {20'h0, md_q.ctrm, md_q.parity_check_disable, 2'h0, md_q.cm, md_q.dir, md_q.algorithm_select}
		: hit_ctrl ? {31'h0, ie_q}
		: hit_cmd ? {28'h0, go_q, 3'h0}
		: hit_stat ? stat_w
		: hit_err ? {21'h0, err_q}
		: hit_mask ? {21'h0, mask_q}
		: hit_ksz ? {26'h0, ksz_q}
		: hit_dsz ? dsz_q
		: hit_out & ~out_empty ? out_mem[out_rp] : 32'h0;

	// ************************************
	// Flip-flops
	// ************************************
	// Bus side survives soft reset so the command write still completes
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			wait_q <= 1'b1;
			rdata_q <= '0;
		end else begin
			wait_q <= I_CE ? ~((I_AVS_READ | I_AVS_WRITE) & wait_q) : 1'b1;
			rdata_q <= rd ? rd_mux : rdata_q;
		end
	end

	// Control and mask survive reinitialise, not soft reset
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			ie_q <= 1'b0;
			mask_q <= scc_pkg::ERR_RST;
		end else if (I_CE) begin
			ie_q <= soft_reset_cmd ? 1'b0 : next_ie;
			mask_q <= soft_reset_cmd ? scc_pkg::ERR_RST : next_mask;
		end
	end

	// Everything else is cleared by either command
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			{md_q, go_q, done_q, irq_q, irq_o, rdone_q, ksz_q, key_ok, par_q, dsz_q, widx} <= '0;
			err_q <= scc_pkg::ERR_RST;
			st <= scc_pkg::ST_IDLE;
			{in_wp, in_rp, out_wp, out_rp, in_cnt, out_cnt} <= '0;
		end else if (I_CE & (soft_reset_cmd | ri)) begin
			{md_q, go_q, done_q, irq_q, rdone_q, ksz_q, key_ok, par_q, dsz_q, widx} <= '0;
			irq_o <= 1'b0;
			err_q <= scc_pkg::ERR_RST;
			st <= scc_pkg::ST_IDLE;
			{in_wp, in_rp, out_wp, out_rp, in_cnt, out_cnt} <= '0;
		end else if (I_CE) begin
			md_q <= mode_w ? to_mode(mode_new) : md_q;
			go_q <= next_go;
			done_q <= next_done;
			irq_q <= next_irq;
			irq_o <= next_irq & next_ie;
			rdone_q <= 1'b1;
			err_q <= next_err;
			st <= scc_pkg::scc_state_e'(next_st);
			ksz_q <= ks_w ? ksz_new[5:0] : ksz_q;
			key_ok <= next_key_ok;
			par_q <= next_par;
			dsz_q <= next_dsz;
			widx <= mv ? widx + 2'h1 : (start ? 2'h0 : widx);
			in_wp <= in_push ? inc(in_wp) : in_wp;
			in_rp <= mv ? inc(in_rp) : in_rp;
			out_wp <= mv ? inc(out_wp) : out_wp;
			out_rp <= out_pop ? inc(out_rp) : out_rp;
			in_cnt <= next_in_cnt;
			out_cnt <= next_out_cnt;
		end
	end

	// FIFO storage, no reset needed since the counts gate it
	always_ff @(posedge I_CLK) begin
		if (I_CE & in_push) begin
			in_mem[in_wp] <= d;
		end
		if (I_CE & mv) begin
			out_mem[out_wp] <= in_mem[in_rp];
		end
	end

	assign O_AVS_READDATA = rdata_q;
	assign O_AVS_WAITREQUEST = wait_q;
	assign O_IRQ = irq_o;

	// ************************************
	// Checks
	// ************************************
	default clocking cb @(posedge I_CLK);
	endclocking
	default disable iff (I_RST);

	sequence s_ack;
		!O_AVS_WAITREQUEST ##1 O_AVS_WAITREQUEST;
	endsequence
	sequence s_err_irq(int b);
		err_q[b] && irq_q;
	endsequence

	AST_BUS_ACK: assert property (acc |=> s_ack)
		else $error("Access not acknowledged after one cycle");
	AST_GO_CLEARS: assert property (I_CE && fin && !go_w && !soft_reset_cmd && !ri |=> !go_q)
		else $error("Finish bit did not clear on completion");
	AST_CI_CLEARS: assert property (ci && !soft_reset_cmd && !ri && evt == '0 && !fin |=> err_q == '0 && !irq_q ##1 !O_IRQ)
		else $error("Clear command left an error or request");
	AST_RI_KEEPS: assert property (I_CE && ri && !soft_reset_cmd |=> ie_q == $past(ie_q) && mask_q == $past(mask_q)
		&& dsz_q == '0 && in_cnt == '0 && st == scc_pkg::ST_IDLE)
		else $error("Reinitialise touched control or mask");
	AST_SWR_RESET: assert property (I_CE && soft_reset_cmd |=> !ie_q && mask_q == '0 && in_cnt == '0 && out_cnt == '0 && !rdone_q)
		else $error("Soft reset left state behind");
	AST_IE_GATES: assert property (!ie_q |-> !O_IRQ && !stat_w[0])
		else $error("Interrupt seen while disabled");
	AST_HALT_FIRST: assert property (I_CE && unm && !soft_reset_cmd && !ri |=> st == scc_pkg::ST_HALT && irq_q
		##1 (err_q == $past(err_q) || !I_CE || $past(ci || soft_reset_cmd || ri)))
		else $error("Unmasked error did not halt or was overwritten");
	AST_IFO: assert property (wr && hit_in && in_full && rec && !mask_q[scc_pkg::E_IFO] && !ci
		|=> s_err_irq(scc_pkg::E_IFO))
		else $error("Full input write not flagged");
	AST_OFU: assert property (rd && hit_out && out_empty && rec && !mask_q[scc_pkg::E_OFU] && !ci
		|=> s_err_irq(scc_pkg::E_OFU) && O_AVS_READDATA == '0)
		else $error("Empty output read not flagged");
	AST_DSZ_DEC: assert property (I_CE && mv && !(wr && (hit_dsz || hit_cmd)) |=> dsz_q == $past(dsz_q) - $past(dec))
		else $error("Data size did not count down");
	// A pending request only falls to the clear or reinitialise command or a reset
	AST_IRQ_HOLDS: assert property (irq_q && !ci && !soft_reset_cmd && !ri |=> irq_q)
		else $error("Interrupt request dropped without a clear");
	AST_DONE_SETS: assert property (I_CE && fin && !soft_reset_cmd && !ri |=> done_q && irq_q && st != scc_pkg::ST_RUN)
		else $error("Finish did not raise done and request");
	AST_BUSY_MODE: assert property (busy && wr && hit_mode |=> md_q == $past(md_q))
		else $error("Mode changed while busy");
	// Sampled reset in the antecedent keeps the release edge out
	AST_RDONE: assert property (!I_RST && I_CE && !soft_reset_cmd && !ri |=> rdone_q)
		else $error("Reset done not reported");
	AST_CE_FREEZE: assert property (!I_CE |=> $stable(st) && $stable(err_q) && $stable(dsz_q) && $stable(irq_o)
		&& O_AVS_WAITREQUEST)
		else $error("State moved while clock enable was low");
endmodule

// *** scc_pkg.sv ***
// Constants, types and the behaviour list of the symmetric cipher control block
// Behaviour
// - Mode bit 2: 0 decrypt, 1 encrypt
// - Algorithm 00 AES, 01 DES, 10 3DES; 11 errors
// - Chaining 00 ECB, 01 CBC, 11 CTR; 10 reserved
// - Control bit 0 enables interrupts, resets 0
// - Command bit 3 finishes processing, self-clears
// - Command bit 2 clears errors and interrupt
// - Command bit 1 clears all but mask, control
// - Command bit 0 equals hardware reset, empties FIFOs; the code keeps waitrequest and read data through it
// - Status read-only; FIFO levels in bits 31-16
// - Status bits 15-8 show engine states
// - Status bit 4 busy; software avoids changes
// - Status bits 3,2,1: reset done, error, done
// - Status bit 0 interrupt, gated by enable
// - Error halts engine, interrupts, keeps first only
// - Error bits 10,8,7,4: key, context, modify, mode
// - Error bit 9 key parity unless disabled
// - Error bits 3,2: FIFO non-empty at start/done
// - Masked errors recorded silently until unmasked one
// - Key size 16/8/16/24 by algorithm else error
// - Key size write starts key setup; busy errors
// - Data size counts down; writes add to it
// - Data size multiple of 8 or 16 else error
// - Input FIFO reads zero; full write errors
// - Output FIFO empty read errors
package scc_pkg;
	// ************************************
	// Register byte addresses
	// ************************************
	localparam logic [23:0] A_MODE = 24'h1b0000;
	localparam logic [23:0] A_CTRL = 24'h1b0004;
	localparam logic [23:0] A_CMD  = 24'h1b0008;
	localparam logic [23:0] A_STAT = 24'h1b000c;
	localparam logic [23:0] A_ERR  = 24'h1b0010;
	localparam logic [23:0] A_MASK = 24'h1b0014;
	localparam logic [23:0] A_KSZ  = 24'h1b0018;
	localparam logic [23:0] A_DSZ  = 24'h1b001c;
	localparam logic [23:0] A_IN   = 24'h1b0020;
	localparam logic [23:0] A_OUT  = 24'h1b0024;
	localparam logic [23:0] A_KEY0 = 24'h1b0030;
	localparam logic [23:0] A_KEY5 = 24'h1b0044;
	localparam logic [23:0] A_CTX0 = 24'h1b0070;
	localparam logic [23:0] A_CTX11 = 24'h1b009c;
	// ************************************
	// Field positions, codes and resets
	// ************************************
	localparam int CMD_GO = 3;
	localparam int CMD_CI = 2;
	localparam int CMD_RI = 1;
	localparam int CMD_SWR = 0;
	localparam int E_KRE = 10;
	localparam int E_KPE = 9;
	localparam int E_ERE = 8;
	localparam int E_RMD = 7;
	localparam int E_KSE = 6;
	localparam int E_DSE = 5;
	localparam int E_IME = 4;
	localparam int E_OUT_FIFO_NONEMPTY_AT_START = 3;
	localparam int E_IN_FIFO_NONEMPTY_AT_DONE = 2;
	localparam int E_OFU = 1;
	localparam int E_IFO = 0;
	localparam int ERR_W = 11;
	localparam logic [1:0] ALG_AES = 2'h0;
	localparam logic [1:0] ALG_RSV = 2'h3;
	localparam logic [1:0] CM_RSV = 2'h2;
	localparam logic [1:0] CM_CTR = 2'h3;
	localparam logic [5:0] KS_16 = 6'h10;
	localparam logic [5:0] KS_8 = 6'h08;
	localparam logic [5:0] KS_24 = 6'h18;
	localparam logic [31:0] WORD_BYTES = 32'h4;
	localparam logic [ERR_W-1:0] ERR_RST = 11'h000;
	localparam int FIFO_DEPTH = 8;
	typedef struct packed {
		logic [3:0] ctrm;
		logic       parity_check_disable;
		logic [1:0] cm;
		logic       dir;
		logic [1:0] algorithm_select;
	} scc_mode_s;
	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_RUN  = 3'h2,
		ST_HALT = 3'h4
	} scc_state_e;
endpackage

// *** symmetric_cipher_control_tb_top.sv ***
// Self-checking testbench of the symmetric cipher control block
module symmetric_cipher_control_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	// ************************************
	// Signals, rows and counters
	// ************************************
	typedef struct {
		logic [23:0] wa;
		logic [31:0] wd;
		logic [23:0] ra;
		logic [31:0] msk;
		logic [31:0] ex;
	} scc_row_s;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        ce = 1'b1;
	logic [3:0]  be = 4'hf;
	logic [23:0] addr = 24'h0;
	logic        rd = 1'b0;
	logic        wr = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata;
	logic        waitreq;
	logic        irq;
	logic [31:0] val;
	int          num_errors = 0;
	int          tests_run = 0;
	scc_row_s    rows [11];

	// Device under test, small FIFO so counts stay readable
	scc_ctrl #(.DEPTH(8)) dut (
		.I_CLK            (clk),
		.I_RST            (rst),
		.I_CE             (ce),
		.I_AVS_ADDRESS    (addr),
		.I_AVS_READ       (rd),
		.I_AVS_WRITE      (wr),
		.I_AVS_WRITEDATA  (wdata),
		.I_AVS_BYTEENABLE (be),
		.O_AVS_READDATA   (rdata),
		.O_AVS_WAITREQUEST(waitreq),
		.O_IRQ            (irq)
	);

	// 125 MHz clock
	always #4 clk = ~clk;

	// ************************************
	// Tasks
	// ************************************
	// Verdict and end of run, also reached by a bus timeout
	task automatic results();
		$display("comparisons %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One Avalon access; request held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [23:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		addr <= a;
		wdata <= d;
		wr <= w;
		rd <= !w;
		do begin
			@(posedge clk);
			n++;
		end while (waitreq !== 1'b0 && n < 64);
		q = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
		@(posedge clk);
		if (n >= 64) begin
			num_errors++;
			$display("mismatch at %0t: waitrequest seen %h expected %h", $time, waitreq, 1'b0);
			results();
		end
	endtask

	task automatic w32(input logic [23:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	task automatic rchk(input logic [23:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		check(q & m, e);
	endtask

	// Interrupt lags its event by one cycle, so let one more edge pass
	task automatic irq_is(input logic e);
		@(posedge clk);
		check({31'h0, irq}, {31'h0, e});
	endtask

	// ************************************
	// Main sequence
	// ************************************
	initial begin
		rows = '{
			'{scc_pkg::A_MODE, 32'h4, scc_pkg::A_MODE, 32'hffffffff, 32'h4},
			'{scc_pkg::A_MODE, 32'h5, scc_pkg::A_MODE, 32'hffffffff, 32'h5},
			'{scc_pkg::A_MODE, 32'h6, scc_pkg::A_MODE, 32'hffffffff, 32'h6},
			'{scc_pkg::A_MODE, 32'h19, scc_pkg::A_MODE, 32'hffffffff, 32'h19},
			'{scc_pkg::A_MODE, 32'h8, scc_pkg::A_MODE, 32'hffffffff, 32'h8},
			'{scc_pkg::A_CTRL, 32'hffffffff, scc_pkg::A_CTRL, 32'hffffffff, 32'h1},
			'{scc_pkg::A_STAT, 32'hffffffff, scc_pkg::A_STAT, 32'hffff001f, 32'h8},
			'{scc_pkg::A_ERR, 32'h7ff, scc_pkg::A_ERR, 32'hffffffff, 32'h0},
			'{scc_pkg::A_IN, 32'h12345678, scc_pkg::A_IN, 32'hffffffff, 32'h0},
			'{24'h1b0028, 32'hffffffff, scc_pkg::A_STAT, 32'h00ff0000, 32'h00010000},
			'{scc_pkg::A_ERR, 32'h0, 24'h1b0028, 32'hffffffff, 32'h0}
		};
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rchk(scc_pkg::A_CTRL, 32'hffffffff, 32'h0);
		rchk(scc_pkg::A_STAT, 32'hff00001f, 32'h8);
		// Register rows: write one address, then read back the same one or another
		foreach (rows[i]) begin
			w32(rows[i].wa, rows[i].wd);
			rchk(rows[i].ra, rows[i].msk, rows[i].ex);
		end
		// Reserved algorithm halts; a later underflow must not be recorded
		w32(scc_pkg::A_MODE, 32'h3);
		irq_is(1'b1);
		bus(1'b0, scc_pkg::A_OUT, 32'h0, val);
		rchk(scc_pkg::A_ERR, 32'hffffffff, 32'h10);
		rchk(scc_pkg::A_STAT, 32'h7, 32'h5);
		irq_is(1'b1);
		w32(scc_pkg::A_CMD, 32'h4);
		irq_is(1'b0);
		rchk(scc_pkg::A_ERR, 32'hffffffff, 32'h0);
		// Soft reset empties the input FIFO and clears control
		w32(scc_pkg::A_CMD, 32'h1);
		rchk(scc_pkg::A_CTRL, 32'hffffffff, 32'h0);
		rchk(scc_pkg::A_STAT, 32'h00ff001f, 32'h8);
		rchk(scc_pkg::A_CMD, 32'hffffffff, 32'h0);
		// Masked underflow stays silent until an unmasked size error
		w32(scc_pkg::A_CTRL, 32'h1);
		w32(scc_pkg::A_MASK, 32'h2);
		bus(1'b0, scc_pkg::A_OUT, 32'h0, val);
		irq_is(1'b0);
		w32(scc_pkg::A_DSZ, 32'h8);
		irq_is(1'b1);
		rchk(scc_pkg::A_ERR, 32'hffffffff, 32'h22);
		// Reinitialise keeps control and mask only
		w32(scc_pkg::A_CMD, 32'h2);
		rchk(scc_pkg::A_CTRL, 32'hffffffff, 32'h1);
		rchk(scc_pkg::A_MASK, 32'hffffffff, 32'h2);
		rchk(scc_pkg::A_ERR, 32'hffffffff, 32'h0);
		rchk(scc_pkg::A_DSZ, 32'hffffffff, 32'h0);
		w32(scc_pkg::A_MASK, 32'h0);
		// Counter mode run of 8 bytes, topped up by 8 while busy
		w32(scc_pkg::A_MODE, 32'h18);
		w32(scc_pkg::A_DSZ, 32'h8);
		w32(scc_pkg::A_KSZ, 32'h10);
		rchk(scc_pkg::A_STAT, 32'h1f, 32'h18);
		w32(scc_pkg::A_DSZ, 32'h8);
		rchk(scc_pkg::A_DSZ, 32'hffffffff, 32'h10);
		w32(scc_pkg::A_IN, 32'ha5a50001);
		w32(scc_pkg::A_IN, 32'ha5a50002);
		rchk(scc_pkg::A_DSZ, 32'hffffffff, 32'h8);
		w32(scc_pkg::A_IN, 32'ha5a50003);
		w32(scc_pkg::A_IN, 32'ha5a50004);
		rchk(scc_pkg::A_DSZ, 32'hffffffff, 32'h0);
		w32(scc_pkg::A_CMD, 32'h8);
		irq_is(1'b1);
		rchk(scc_pkg::A_STAT, 32'hff00001f, 32'h0400000b);
		rchk(scc_pkg::A_CMD, 32'hffffffff, 32'h0);
		rchk(scc_pkg::A_OUT, 32'hffffffff, 32'ha5a50001);
		rchk(scc_pkg::A_ERR, 32'hffffffff, 32'h0);
		// New start while output still holds words
		w32(scc_pkg::A_CMD, 32'h4);
		w32(scc_pkg::A_DSZ, 32'h8);
		rchk(scc_pkg::A_ERR, 32'hffffffff, 32'h8);
		irq_is(1'b1);
		// Mode write while busy is refused and flagged
		w32(scc_pkg::A_CMD, 32'h1);
		w32(scc_pkg::A_KSZ, 32'h10);
		w32(scc_pkg::A_DSZ, 32'h10);
		w32(scc_pkg::A_MODE, 32'h4);
		rchk(scc_pkg::A_MODE, 32'hffffffff, 32'h0);
		rchk(scc_pkg::A_ERR, 32'hffffffff, 32'h80);
		// Even-parity key bytes pass only with the check disabled
		w32(scc_pkg::A_CMD, 32'h1);
		w32(scc_pkg::A_MODE, 32'h81);
		w32(scc_pkg::A_KEY0, 32'h0);
		w32(scc_pkg::A_KEY0 + 24'h4, 32'h0);
		w32(scc_pkg::A_KSZ, 32'h8);
		rchk(scc_pkg::A_ERR, 32'hffffffff, 32'h0);
		// Parity is judged per key load, so the key goes in again
		w32(scc_pkg::A_MODE, 32'h1);
		w32(scc_pkg::A_KEY0, 32'h0);
		w32(scc_pkg::A_KEY0 + 24'h4, 32'h0);
		w32(scc_pkg::A_KSZ, 32'h8);
		rchk(scc_pkg::A_ERR, 32'hffffffff, 32'h200);
		// Three-key size under the wide algorithm, interrupts disabled
		w32(scc_pkg::A_CMD, 32'h1);
		w32(scc_pkg::A_KSZ, 32'h18);
		rchk(scc_pkg::A_ERR, 32'hffffffff, 32'h40);
		rchk(scc_pkg::A_STAT, 32'h7, 32'h4);
		irq_is(1'b0);
		// Unmasked underflow, then overflow of a full input FIFO after a clear
		w32(scc_pkg::A_CMD, 32'h1);
		bus(1'b0, scc_pkg::A_OUT, 32'h0, val);
		rchk(scc_pkg::A_ERR, 32'hffffffff, 32'h2);
		w32(scc_pkg::A_CMD, 32'h4);
		for (int i = 0; i < 9; i++) begin
			w32(scc_pkg::A_IN, 32'(i));
		end
		rchk(scc_pkg::A_ERR, 32'hffffffff, 32'h1);
		rchk(scc_pkg::A_STAT, 32'h00ff0000, 32'h00080000);
		// A write on byte lane 1 only leaves the enable bit alone
		w32(scc_pkg::A_CTRL, 32'h1);
		be <= 4'h2;
		w32(scc_pkg::A_CTRL, 32'h0);
		be <= 4'hf;
		rchk(scc_pkg::A_CTRL, 32'hffffffff, 32'h1);
		// Clock enable low holds off the access until it returns
		ce <= 1'b0;
		fork
			w32(scc_pkg::A_CTRL, 32'h0);
			begin
				repeat (4) @(posedge clk);
				check({31'h0, waitreq}, 32'h1);
				ce <= 1'b1;
			end
		join
		rchk(scc_pkg::A_CTRL, 32'hffffffff, 32'h0);
		// Hardware reset while halted clears what soft reset clears
		w32(scc_pkg::A_MASK, 32'h7ff);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rchk(scc_pkg::A_MASK, 32'hffffffff, 32'h0);
		rchk(scc_pkg::A_STAT, 32'h00ff001f, 32'h8);
		results();
	end
endmodule
